// *** logic/ups_params.svh ***
`ifndef UPS_PARAMS_SVH
`define UPS_PARAMS_SVH
// Register byte offsets
`define UPS_ADDR_W 4
`define UPS_OFF_STATUS 4'h0
`define UPS_OFF_DATA 4'h4
`define UPS_OFF_CTRL1 4'h8
`define UPS_OFF_CTRL2 4'hC
// Reset values
`define UPS_RST_STATUS 8'hC0
`define UPS_RST_CTRL 8'h00
// Status bit positions
`define UPS_SB_TXE 7
`define UPS_SB_TXD 6
`define UPS_SB_RXF 5
`define UPS_SB_IDLE 4
`define UPS_SB_OVR 3
`define UPS_SB_NOISE 2
`define UPS_SB_FRAME 1
`define UPS_SB_PERR 0
// Flag groups by clearing access
`define UPS_TX_FLAGS 8'hC0
`define UPS_RX_FLAGS 8'h3E
`define UPS_PE_FLAGS 8'h01
// Control one bit positions
`define UPS_C1_RX8 7
`define UPS_C1_TX8 6
`define UPS_C1_LEN9 4
`define UPS_C1_WAKE 3
`define UPS_C1_PEN 2
`define UPS_C1_PODD 1
`define UPS_C1_PIE 0
`define UPS_C1_SW_MASK 8'h7F
// Control two bit positions
`define UPS_C2_TIE 7
`define UPS_C2_TX_DONE_IRQ_EN 6
`define UPS_C2_RIE 5
`define UPS_C2_QUIET_IRQ_EN 4
`define UPS_C2_TE 3
`define UPS_C2_RE 2
// Bus answers
`define UPS_RESP_OK 2'h0
`define UPS_RESP_ERR 2'h2
`endif

// *** logic/ups_pkg.sv ***
package ups_pkg;

  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] arm;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] tx_hold;
    logic [8:0] tx_frame;
    logic [7:0] rx_hold;
    logic rx_odd;
    logic idle_allow;
    logic addr_mark;
    logic aw_got;
    logic [3:0] wr_addr;
    logic w_got;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ups_state_t;

endpackage : ups_pkg

// *** logic/ups_serial_status.sv ***
// Contract
// - Frame length follows parity and nine-bit setting
// - Even parity makes total ones even
// - Odd parity makes total ones odd
// - Parity replaces written word's top bit
// - Receive parity mismatch sets error flag
// - Address mark tests data MSB, not parity
// - Wait keeps working; enabled events wake
// - Halt freezes all registers and transfers
// - One request line, per-event enable, mask
// - Receive ready wakes Wait, never Halt
// - Buffer empty on load; sequence clears
// - Done after data characters only
// - Receive full set; status then read clears
// - Idle rearmed only by next receive full
// - Overrun keeps old word, flags, interrupts
// - Noise flag, no own interrupt
// - Framing flag; overrun suppresses it
// - Parity flag cleared by status then data
// - Status reads C0 after reset
// - Parity select applies from next character
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ups_params.svh"

module ups_serial_status (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic cpu_halt,
  input wire logic cpu_imask,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic tx_enable,
  output logic rx_enable,
  output logic frame_nine_bits,
  output logic frame_parity,
  output logic tx_hold_valid,
  input wire logic tx_take,
  output logic [8:0] tx_frame_word,
  input wire logic tx_char_done,
  input wire logic tx_char_data,
  input wire logic rx_start,
  input wire logic rx_word_valid,
  input wire logic [8:0] rx_word,
  input wire logic rx_noise,
  input wire logic rx_framing,
  input wire logic rx_idle_det,
  output logic addr_mark_bit,
  output logic irq_req,
  output logic wait_wake
);
  import ups_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State and handshakes

  ups_state_t s;
  ups_state_t next_s;
  ups_state_t rst_s;

  logic adv;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic wr_hit;
  logic rd_hit;
  logic wr_dreg;
  logic rd_dreg;
  logic rd_stat;
  logic [7:0] rd_mux;
  logic rx_perr;
  logic rx_mark;

  // Halt gates every flop, bus side included
  assign adv = ce & ~cpu_halt;

  // Nothing is taken while frozen, so no handshake is lost
  assign awready = ~s.aw_got & ~s.bvalid & adv;
  assign wready = ~s.w_got & ~s.bvalid & adv;
  assign arready = ~s.rvalid & adv;
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign wr_do = s.aw_got & s.w_got & ~s.bvalid;

  assign wr_hit = (s.wr_addr == `UPS_OFF_STATUS) |
                  (s.wr_addr == `UPS_OFF_DATA) |
                  (s.wr_addr == `UPS_OFF_CTRL1) |
                  (s.wr_addr == `UPS_OFF_CTRL2);
  assign rd_hit = (araddr == `UPS_OFF_STATUS) |
                  (araddr == `UPS_OFF_DATA) |
                  (araddr == `UPS_OFF_CTRL1) |
                  (araddr == `UPS_OFF_CTRL2);
  assign wr_dreg = wr_do & s.wr_lane0 & (s.wr_addr == `UPS_OFF_DATA);
  assign rd_dreg = ar_take & (araddr == `UPS_OFF_DATA);
  assign rd_stat = ar_take & (araddr == `UPS_OFF_STATUS);

  always_comb begin
    unique case (araddr)
      `UPS_OFF_STATUS: rd_mux = s.stat;
      `UPS_OFF_DATA: rd_mux = s.rx_hold;
      `UPS_OFF_CTRL1: rd_mux = s.ctrl1;
      `UPS_OFF_CTRL2: rd_mux = s.ctrl2;
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Parity helpers

  // Builds the outgoing frame from the holding word
  function automatic logic [8:0] f_tx_frame(
    input logic [7:0] hold,
    input logic [7:0] c1
  );
    logic [8:0] f;
    f = {c1[`UPS_C1_TX8], hold};
    if (c1[`UPS_C1_PEN]) begin
      if (c1[`UPS_C1_LEN9]) begin
        f[8] = (^hold) ^ c1[`UPS_C1_PODD];
      end else begin
        f[7] = (^hold[6:0]) ^ c1[`UPS_C1_PODD];
      end
    end
    if (!c1[`UPS_C1_LEN9]) begin
      f[8] = 1'b0;
    end
    return f;
  endfunction : f_tx_frame

  // Received parity checked with the select latched at frame start
  always_comb begin
    if (s.ctrl1[`UPS_C1_LEN9]) begin
      rx_perr = (^rx_word[8:0]) != s.rx_odd;
    end else begin
      rx_perr = (^rx_word[7:0]) != s.rx_odd;
    end
  end

  // Mark bit is the top data bit, below any parity bit
  always_comb begin
    unique case ({s.ctrl1[`UPS_C1_LEN9], s.ctrl1[`UPS_C1_PEN]})
      2'h0: rx_mark = rx_word[7];
      2'h1: rx_mark = rx_word[6];
      2'h2: rx_mark = rx_word[8];
      2'h3: rx_mark = rx_word[7];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    rst_s = '0;
    rst_s.stat = `UPS_RST_STATUS;
    rst_s.ctrl1 = `UPS_RST_CTRL;
    rst_s.ctrl2 = `UPS_RST_CTRL;
    rst_s.idle_allow = 1'b1;

    next_s = s;

    // Bus write channels, taken in either order
    if (aw_take) begin
      next_s.aw_got = 1'b1;
      next_s.wr_addr = awaddr;
    end
    if (w_take) begin
      next_s.w_got = 1'b1;
      next_s.wr_data = wdata[7:0];
      next_s.wr_lane0 = wstrb[0];
    end
    if (wr_do) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? `UPS_RESP_OK : `UPS_RESP_ERR;
      if (s.wr_lane0 && s.wr_addr == `UPS_OFF_CTRL1) begin
        next_s.ctrl1 = (s.ctrl1 & ~`UPS_C1_SW_MASK) |
                       (s.wr_data & `UPS_C1_SW_MASK);
      end
      if (s.wr_lane0 && s.wr_addr == `UPS_OFF_CTRL2) begin
        next_s.ctrl2 = s.wr_data;
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // Bus read channel
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_mux;
      next_s.rresp = rd_hit ? `UPS_RESP_OK : `UPS_RESP_ERR;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    // Clearing sequences; sets further down win
    if (wr_dreg) begin
      next_s.tx_hold = s.wr_data;
      next_s.stat = next_s.stat & ~(s.arm & `UPS_TX_FLAGS);
      next_s.arm = next_s.arm & ~`UPS_TX_FLAGS;
    end
    if (rd_dreg) begin
      next_s.stat = next_s.stat & ~(s.arm & `UPS_RX_FLAGS);
      next_s.arm = next_s.arm & ~`UPS_RX_FLAGS;
    end
    if (wr_dreg || rd_dreg) begin
      next_s.stat = next_s.stat & ~(s.arm & `UPS_PE_FLAGS);
      next_s.arm = next_s.arm & ~`UPS_PE_FLAGS;
    end
    // Each flag seen set by a status read is armed
    if (rd_stat) begin
      next_s.arm = s.stat;
    end

    // Transmit side
    if (tx_take && tx_hold_valid) begin
      next_s.stat[`UPS_SB_TXE] = 1'b1;
      next_s.tx_frame = f_tx_frame(s.tx_hold, s.ctrl1);
    end
    if (tx_char_done && tx_char_data) begin
      next_s.stat[`UPS_SB_TXD] = 1'b1;
    end

    // Receive side
    if (rx_start) begin
      next_s.rx_odd = s.ctrl1[`UPS_C1_PODD];
    end
    if (rx_idle_det && s.idle_allow && s.ctrl2[`UPS_C2_RE]) begin
      next_s.stat[`UPS_SB_IDLE] = 1'b1;
      next_s.idle_allow = 1'b0;
    end
    if (rx_word_valid && s.ctrl2[`UPS_C2_RE]) begin
      next_s.addr_mark = rx_mark;
      if (s.stat[`UPS_SB_RXF]) begin
        // Old word kept, framing not reported
        next_s.stat[`UPS_SB_OVR] = 1'b1;
      end else begin
        next_s.rx_hold = rx_word[7:0];
        next_s.ctrl1[`UPS_C1_RX8] = rx_word[8];
        next_s.stat[`UPS_SB_RXF] = 1'b1;
        next_s.idle_allow = 1'b1;
        if (rx_noise) begin
          next_s.stat[`UPS_SB_NOISE] = 1'b1;
        end
        if (rx_framing) begin
          next_s.stat[`UPS_SB_FRAME] = 1'b1;
        end
        if (s.ctrl1[`UPS_C1_PEN] && rx_perr) begin
          next_s.stat[`UPS_SB_PERR] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= rst_s;
    end else if (adv) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = {24'h000000, s.rdata};
  assign tx_enable = s.ctrl2[`UPS_C2_TE];
  assign rx_enable = s.ctrl2[`UPS_C2_RE];
  assign frame_nine_bits = s.ctrl1[`UPS_C1_LEN9];
  assign frame_parity = s.ctrl1[`UPS_C1_PEN];
  assign tx_hold_valid = ~s.stat[`UPS_SB_TXE] & s.ctrl2[`UPS_C2_TE];
  assign tx_frame_word = s.tx_frame;
  assign addr_mark_bit = s.addr_mark;

  // Every event except noise and framing shares one request line behind the global mask
  assign irq_req = ~cpu_imask & (
    (s.ctrl2[`UPS_C2_TIE] & s.stat[`UPS_SB_TXE]) |
    (s.ctrl2[`UPS_C2_TX_DONE_IRQ_EN] & s.stat[`UPS_SB_TXD]) |
    (s.ctrl2[`UPS_C2_RIE] &
      (s.stat[`UPS_SB_RXF] | s.stat[`UPS_SB_OVR])) |
    (s.ctrl2[`UPS_C2_QUIET_IRQ_EN] & s.stat[`UPS_SB_IDLE]) |
    (s.ctrl1[`UPS_C1_PIE] & s.stat[`UPS_SB_PERR]));

  // Wait exit only; no path here ends a Halt
  assign wait_wake = irq_req;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_tx_load;
    adv && tx_take && tx_hold_valid;
  endsequence

  sequence s_rx_clash;
    adv && rx_word_valid && s.ctrl2[`UPS_C2_RE] && s.stat[`UPS_SB_RXF];
  endsequence

  sequence s_armed_drd;
    adv && rd_dreg && s.arm[`UPS_SB_RXF] && !rx_word_valid;
  endsequence

  property p_par_short;
    (s_tx_load and (s.ctrl1[`UPS_C1_PEN] && !s.ctrl1[`UPS_C1_LEN9]))
      |=> (^tx_frame_word[7:0]) == $past(s.ctrl1[`UPS_C1_PODD]);
  endproperty
  a_par_short: assert property (p_par_short)
    else $error("tx parity bit wrong");

  property p_msb_swap;
    (s_tx_load and s.ctrl1[`UPS_C1_PEN])
      |=> tx_frame_word[6:0] == $past(s.tx_hold[6:0]) &&
          tx_frame_word[8] == ($past(s.ctrl1[`UPS_C1_LEN9]) ?
            ((^$past(s.tx_hold)) ^ $past(s.ctrl1[`UPS_C1_PODD])) : 1'b0);
  endproperty
  a_msb_swap: assert property (p_msb_swap)
    else $error("tx frame data or parity wrong");

  property p_reset_stat;
    $past(sys_rst) |-> s.stat == `UPS_RST_STATUS;
  endproperty
  a_reset_stat: assert property (p_reset_stat)
    else $error("status not C0 after reset");

  property p_overrun;
    s_rx_clash |=> s.stat[`UPS_SB_OVR] &&
      s.rx_hold == $past(s.rx_hold) &&
      !$rose(s.stat[`UPS_SB_FRAME]);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun handling wrong");

  property p_irq_mask;
    cpu_imask |-> !irq_req && !wait_wake;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("request while masked");

  property p_halt_freeze;
    cpu_halt ##1 !sys_rst |-> s == $past(s);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("state moved during halt");

  property p_rxf_clear;
    s_armed_drd |=> !s.stat[`UPS_SB_RXF];
  endproperty
  a_rxf_clear: assert property (p_rxf_clear)
    else $error("receive full not cleared");

  property p_rx_wait;
    (s.ctrl2[`UPS_C2_RIE] && s.stat[`UPS_SB_RXF] && !cpu_imask)
      |-> wait_wake;
  endproperty
  a_rx_wait: assert property (p_rx_wait)
    else $error("receive full did not wake");

  property p_idle_once;
    (adv && s.stat[`UPS_SB_IDLE] && !s.idle_allow && !rx_word_valid)
      |=> !s.idle_allow;
  endproperty
  a_idle_once: assert property (p_idle_once)
    else $error("idle rearmed without receive");

endmodule : ups_serial_status

// *** tb/ups_node_model.sv ***
`timescale 1ns/1ps
module ups_node_model (
  input wire logic mclk,
  input wire logic tx_hold_valid,
  input wire logic [8:0] tx_frame_word,
  output logic tx_take,
  output logic tx_char_done,
  output logic tx_char_data,
  output logic rx_start,
  output logic rx_word_valid,
  output logic [8:0] rx_word,
  output logic rx_noise,
  output logic rx_framing,
  output logic rx_idle_det
);
  logic [8:0] got_q[$];
  logic brk = 1'b0;
  initial begin
    {tx_take, tx_char_done, tx_char_data, rx_start} = '0;
    {rx_word_valid, rx_word, rx_noise, rx_framing, rx_idle_det} = '0;
  end
  //////////////////////////////////////////////////
  // Takes each waiting word, then reports its end
  always begin
    @(posedge mclk);
    if (tx_hold_valid === 1'b1) begin
      tx_take <= 1'b1;
      @(posedge mclk);
      tx_take <= 1'b0;
      @(posedge mclk);
      got_q.push_back(tx_frame_word);
      tx_char_done <= 1'b1;
      tx_char_data <= !brk;
      @(posedge mclk);
      tx_char_done <= 1'b0;
    end
  end
  task automatic rx_send(input logic [8:0] w, input logic nz, input logic fr);
    @(posedge mclk);
    rx_start <= 1'b1;
    @(posedge mclk);
    rx_start <= 1'b0;
    rx_word_valid <= 1'b1;
    rx_word <= w;
    rx_noise <= nz;
    rx_framing <= fr;
    @(posedge mclk);
    rx_word_valid <= 1'b0;
    rx_word <= ~w;
  endtask : rx_send
  task automatic idle_pulse;
    @(posedge mclk);
    rx_idle_det <= 1'b1;
    @(posedge mclk);
    rx_idle_det <= 1'b0;
  endtask : idle_pulse
endmodule : ups_node_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "ups_params.svh"
module tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, ce = 1'b1, cpu_halt = 1'b0;
  logic cpu_imask = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, addr_mark_bit;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic tx_enable, rx_enable, frame_nine_bits, frame_parity, tx_hold_valid;
  logic irq_req, wait_wake, tx_take, tx_char_done, tx_char_data, rx_start;
  logic rx_word_valid, rx_noise, rx_framing, rx_idle_det;
  logic [8:0] tx_frame_word, rx_word, w, exp_f;
  logic [7:0] d;
  int mismatches = 0;
  int comparisons = 0;
  int est = 8'hC0;
  int arm = 0;
  always #2.5 mclk = ~mclk;
  ups_serial_status dut_u (.mclk, .sys_rst, .ce, .cpu_halt, .cpu_imask,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .tx_enable, .rx_enable, .frame_nine_bits, .frame_parity,
    .tx_hold_valid, .tx_take, .tx_frame_word, .tx_char_done, .tx_char_data,
    .rx_start, .rx_word_valid, .rx_word, .rx_noise, .rx_framing,
    .rx_idle_det, .addr_mark_bit, .irq_req, .wait_wake);
  ups_node_model u_node (.mclk, .tx_hold_valid, .tx_frame_word, .tx_take,
    .tx_char_done, .tx_char_data, .rx_start, .rx_word_valid, .rx_word,
    .rx_noise, .rx_framing, .rx_idle_det);
  //////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic axw(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("bresp", bresp, a[1:0] == 2'h0 ? `UPS_RESP_OK : `UPS_RESP_ERR);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    check("rresp", rs, a[1:0] == 2'h0 ? `UPS_RESP_OK : `UPS_RESP_ERR);
    rready <= 1'b0;
  endtask : axr
  task automatic rd_st;
    axr(`UPS_OFF_STATUS);
    check("status", rd, est);
    arm = est;
  endtask : rd_st
  task automatic rx_clear;
    axr(`UPS_OFF_DATA);
    est = est & ~(arm & 8'h3F);
  endtask : rx_clear
  function automatic logic par(input logic [7:0] v, input logic nine,
                               input logic odd);
    return (nine ? ^v : ^v[6:0]) ^ odd;
  endfunction : par
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end
  //////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hB953F433));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_st();
    axr(4'h2);
    check("unmapped", rs, `UPS_RESP_ERR);
    axw(4'h6, 8'hFF);
    axw(`UPS_OFF_CTRL2, 8'h8C);
    @(posedge mclk);
    check("irq", irq_req, 1'b1);
    check("wake", wait_wake, 1'b1);
    check("tx_en", tx_enable, 1'b1);
    check("rx_en", rx_enable, 1'b1);
    cpu_imask <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    check("masked", irq_req, 1'b0);
    cpu_imask <= 1'b0;
    axw(`UPS_OFF_CTRL2, 8'h0C);
    // Parity on/off, even/odd, 8/9 bits, then one break character
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom);
      u_node.brk = (i == 8);
      axw(`UPS_OFF_CTRL1, {3'h0, i[2], 1'b0, i[0], i[1], 1'b0});
      check("nine", frame_nine_bits, i[2]);
      check("par_on", frame_parity, i[0]);
      rd_st();
      check("hold_idle", tx_hold_valid, 1'b0);
      axw(`UPS_OFF_DATA, d);
      check("hold_ready", tx_hold_valid, 1'b1);
      while (u_node.got_q.size() == 0) @(posedge mclk);
      w = u_node.got_q.pop_front();
      exp_f = i[2] ? {i[0] ? par(d, 1'b1, i[1]) : 1'b0, d}
        : {1'b0, i[0] ? par(d, 1'b0, i[1]) : d[7], d[6:0]};
      check("frame", w, exp_f);
      repeat (3) @(posedge mclk);
      est = (i == 8) ? 8'h80 : 8'hC0;
      rd_st();
    end
    axw(`UPS_OFF_CTRL1, 8'h05);
    axw(`UPS_OFF_CTRL2, 8'h2C);
    axr(`UPS_OFF_CTRL2);
    check("ctrl2", rd, 8'h2C);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      w = {1'b0, par(d, 1'b0, 1'b0) ^ i[0], d[6:0]};
      u_node.rx_send(w, i[1], i[1] ^ i[0]);
      est = est | 8'h20 | (i[1] ? 4 : 0) | (i[0] ? 1 : 0) |
        ((i[1] ^ i[0]) ? 2 : 0);
      @(posedge mclk);
      check("rx_irq", irq_req, 1'b1);
      check("mark", addr_mark_bit, d[6]);
      rd_st();
      rx_clear();
      check("rx_data", rd, w[7:0]);
      rd_st();
    end
    d = 8'($urandom);
    w = {1'b0, par(d, 1'b0, 1'b0), d[6:0]};
    u_node.rx_send(w, 1'b0, 1'b0);
    u_node.rx_send(~w, 1'b0, 1'b1);
    est = est | 8'h28;
    rd_st();
    rx_clear();
    check("kept", rd, w[7:0]);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) u_node.rx_send(w, 1'b0, 1'b0);
      u_node.idle_pulse();
      est = est | (i == 1 ? 0 : 8'h10) | (i == 2 ? 8'h20 : 0);
      rd_st();
      rx_clear();
    end
    cpu_halt <= 1'b1;
    u_node.rx_send(w, 1'b0, 1'b0);
    cpu_halt <= 1'b0;
    rd_st();
    stop_test();
  end
endmodule : tb_top
